// ---- rtl/pls_power_saver.sv ----
// Overview of operation
// [R01] enter tx lpi only on inband request
// [R02] send sleep symbols after accepting request
// [R03] 100 mb/s: quiet right after sleep
// [R04] 1000 mb/s: quiet after sleep both ways
// [R05] refresh periodically while quiet until exit
// [R06] request bit cleared means exit lpi
// [R07] exit sends wake symbols, then active
// [R08] controller waits system wake time before data
// [R09] report partner lpi to controller
// [R10] time sleep, quiet and refresh intervals
// [R11] exit never shorter than phy wake time
// [R12] advertise eee via next pages
// [R13] autoneg at powerup, command, error, reconnect
// [R14] lpi only if both advertised eee
// [R15] no half duplex/10m/proxy with eee
// [R16] battery saver always on, hardware only
// [R17] reconnect tries 1000, 100, then 10
// [R18] battery saver only with autonegotiation
// [R19] gate crystal drivers intermittently while saving
// [R20] low_power_link_up tries 10 first, then higher
// [R21] low_power_link_up change never starts autonegotiation
// [R22] nvm word bit enables low_power_link_up off-d0a
// [R23] ignore lpi request at half/10m
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module pls_power_saver (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // inband side
  input  wire logic        ib_valid,
  input  wire logic        ib_lpi_tx_req,
  output logic             ib_rx_lpi_ind,
  // line side status
  input  wire logic        rx_sleep_seen,
  input  wire logic        rx_partner_lpi,
  input  wire logic        energy_detect,
  input  wire logic        phy_error,
  input  wire logic        partner_eee,
  input  wire logic [2:0]  partner_speeds,
  input  wire logic        an_attempt_ok,
  input  wire logic        an_attempt_done,
  input  wire logic        full_duplex,
  input  wire logic        fully_active_device_state,
  output logic      [1:0]  tx_sym,
  output logic             an_start,
  output logic      [1:0]  an_try_speed,
  output logic             an_next_page_eee,
  output logic             xtal_drv_en,
  output logic             cable_disconnect_battery_saver
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] ctrl_q, ctrl_d, adv_q, adv_d, nvm_q, nvm_d, rdat_d;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic        an_cmd;
  pls_pkg::pls_tx_t tx_q, tx_d;
  pls_pkg::pls_an_t an_q, an_d;
  logic [1:0]  spd_q, spd_d;
  logic        link_up_q, link_up_d;
  logic [1:0]  link_spd_q, link_spd_d;
  logic        link_fd_q, link_fd_d;
  logic        link_eee_q, link_eee_d;
  logic        energy_q;

  function automatic logic [1:0] pls_next_speed(input logic [1:0] s, input logic up);
    if (up) pls_next_speed = (s == pls_pkg::SPD_1000) ? s : s + 2'h1;
    else    pls_next_speed = (s == pls_pkg::SPD_10) ? s : s - 2'h1;
  endfunction

  // low_power_link_up enable: control bit when fully active, nvm bit otherwise
  logic low_power_link_up_en;
  assign low_power_link_up_en = fully_active_device_state ? ctrl_q[pls_pkg::CTRL_LOW_POWER_LINK_UP]
                                             : nvm_q[pls_pkg::NVM_LOW_POWER_LINK_UP_BIT]; // [R22]

  always_comb begin
    ctrl_d    = ctrl_q;
    adv_d     = adv_q;
    nvm_d     = nvm_q;
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    an_cmd    = 1'b0;
    rdat_d    = 32'h0000_0000;
    if (wr_pend_q) begin
      case (wr_addr_q)
        pls_pkg::CTRL_OFS: begin
          // self-clearing restart bit; low_power_link_up bit alone starts nothing
          ctrl_d = hwdata & ~(32'h0000_0001 << pls_pkg::CTRL_AN_RST); // [R21]
          an_cmd = hwdata[pls_pkg::CTRL_AN_RST]; // [R13]
        end
        pls_pkg::ADV_OFS:   adv_d = hwdata;
        pls_pkg::NVM17_OFS: nvm_d = hwdata;
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        wr_pend_d = 1'b1;
        wr_addr_d = haddr;
      end else begin
        case (haddr)
          pls_pkg::CTRL_OFS:  rdat_d = ctrl_q;
          // status word: link fields low, fsm states above, rest reads zero
          pls_pkg::STAT_OFS:  rdat_d = {18'h0_0000,
                                        tx_q,
                                        an_q,
                                        link_eee_q,
                                        link_fd_q,
                                        link_spd_q,
                                        link_up_q};
          pls_pkg::ADV_OFS:   rdat_d = adv_q;
          pls_pkg::NVM17_OFS: rdat_d = nvm_q;
          default:            rdat_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= pls_pkg::CTRL_RST;
      adv_q     <= pls_pkg::ADV_RST;
      nvm_q     <= pls_pkg::NVM17_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      ctrl_q    <= ctrl_d;
      adv_q     <= adv_d;
      nvm_q     <= nvm_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      // zero wait states: read data stands in the data phase that follows
      hrdata    <= rdat_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // auto-negotiation and battery saver

  logic        por_q, por_d;
  logic        an_start_d, save_d, xtal_d;
  logic [1:0]  try_d;
  logic [7:0]  xcnt_q, xcnt_d;
  logic        reconnect;
  logic        low_power_link_up_run_q, low_power_link_up_run_d;
  logic        np_eee_d;

  assign reconnect = energy_detect && !energy_q;

  always_comb begin
    an_d       = an_q;
    spd_d      = spd_q;
    por_d      = 1'b0;
    an_start_d = 1'b0;
    link_up_d  = link_up_q;
    link_spd_d = link_spd_q;
    link_fd_d  = link_fd_q;
    link_eee_d = link_eee_q;
    xcnt_d     = xcnt_q;
    xtal_d     = 1'b1;
    save_d     = 1'b0;
    low_power_link_up_run_d = low_power_link_up_run_q;
    np_eee_d   = ctrl_q[pls_pkg::CTRL_EEE_EN]; // [R12]
    case (an_q)
      pls_pkg::PLS_AN_IDLE: begin
        if (por_q || an_cmd || phy_error || reconnect) begin // [R13]
          an_d       = pls_pkg::PLS_AN_RUN;
          an_start_d = 1'b1;
          link_up_d  = 1'b0;
          // low_power_link_up starts at 10, otherwise top speed first
          spd_d = low_power_link_up_en ? pls_pkg::SPD_10 : pls_pkg::SPD_1000; // [R17] [R20]
          // setting frozen for the whole negotiation; changes wait for the next one
          low_power_link_up_run_d = low_power_link_up_en; // [R21]
        end
      end
      pls_pkg::PLS_AN_RUN: begin
        if (!energy_detect && !ctrl_q[pls_pkg::CTRL_FORCED]) begin
          an_d = pls_pkg::PLS_AN_SAVE; // [R18]
        end else if (an_attempt_done) begin
          if (an_attempt_ok) begin
            an_d       = pls_pkg::PLS_AN_LINK;
            link_up_d  = 1'b1;
            link_spd_d = spd_q;
            link_fd_d  = full_duplex;
            // eee used only if both sides advertised it
            link_eee_d = partner_eee && ctrl_q[pls_pkg::CTRL_EEE_EN]; // [R14]
          end else if (low_power_link_up_run_q && spd_q != pls_pkg::SPD_1000) begin
            spd_d      = pls_next_speed(spd_q, 1'b1); // [R20]
            an_start_d = 1'b1;
          end else if (!low_power_link_up_run_q && spd_q != pls_pkg::SPD_10) begin
            spd_d      = pls_next_speed(spd_q, 1'b0); // [R17]
            an_start_d = 1'b1;
          end else begin
            an_d = pls_pkg::PLS_AN_IDLE;
          end
        end
      end
      pls_pkg::PLS_AN_LINK: begin
        if (phy_error || an_cmd) begin
          an_d = pls_pkg::PLS_AN_IDLE;
          por_d = 1'b1;
          link_up_d = 1'b0;
        end else if (!energy_detect && !ctrl_q[pls_pkg::CTRL_FORCED]) begin
          an_d      = pls_pkg::PLS_AN_SAVE; // [R16] [R18]
          link_up_d = 1'b0;
        end
      end
      pls_pkg::PLS_AN_SAVE: begin
        save_d = 1'b1;
        // duty-cycle crystal drivers; trades wake latency for power
        xcnt_d = xcnt_q + 8'h01;
        if (xcnt_q >= 8'(pls_pkg::XTAL_OFF_CYC + pls_pkg::XTAL_ON_CYC - 1)) xcnt_d = 8'h00;
        xtal_d = (xcnt_q >= 8'(pls_pkg::XTAL_OFF_CYC)); // [R19]
        if (energy_detect) begin
          an_d   = pls_pkg::PLS_AN_IDLE;
          por_d  = 1'b1; // reconnect renegotiates [R13] [R17]
          save_d = 1'b0;
          xtal_d = 1'b1;
        end
      end
      default: an_d = pls_pkg::PLS_AN_IDLE;
    endcase
    try_d = spd_d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      an_q     <= pls_pkg::PLS_AN_IDLE;
      spd_q    <= pls_pkg::SPD_1000;
      por_q    <= 1'b1;
      energy_q <= 1'b0;
      link_up_q  <= 1'b0;
      link_spd_q <= pls_pkg::SPD_10;
      link_fd_q  <= 1'b0;
      link_eee_q <= 1'b0;
      xcnt_q   <= 8'h00;
      low_power_link_up_run_q <= 1'b0;
      an_start <= 1'b0;
      an_try_speed <= pls_pkg::SPD_1000;
      an_next_page_eee <= 1'b0;
      xtal_drv_en <= 1'b1;
      cable_disconnect_battery_saver <= 1'b0;
    end else if (clk_en) begin
      an_q     <= an_d;
      spd_q    <= spd_d;
      por_q    <= por_d;
      energy_q <= energy_detect;
      link_up_q  <= link_up_d;
      link_spd_q <= link_spd_d;
      link_fd_q  <= link_fd_d;
      link_eee_q <= link_eee_d;
      xcnt_q   <= xcnt_d;
      low_power_link_up_run_q <= low_power_link_up_run_d;
      an_start <= an_start_d;
      an_try_speed <= try_d;
      an_next_page_eee <= np_eee_d;
      xtal_drv_en <= xtal_d;
      cable_disconnect_battery_saver <= save_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit lpi sequencer

  logic [pls_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic        req_q, req_d;
  logic        rx_sleep_q, rx_sleep_d;
  logic        lpi_ok;
  logic [1:0]  sym_d;
  logic        rx_ind_d;

  // lpi not allowed at 10 mb/s, half duplex or with proxy offload
  assign lpi_ok = link_up_q && link_eee_q && link_fd_q && !ctrl_q[pls_pkg::CTRL_PROXY]
                  && link_spd_q != pls_pkg::SPD_10; // [R14] [R15] [R23]

  always_comb begin
    tx_d       = tx_q;
    cnt_d      = cnt_q;
    // the request bit is only meaningful alongside ib_valid
    req_d      = ib_valid ? ib_lpi_tx_req : req_q; // [R06]
    rx_sleep_d = rx_sleep_q | rx_sleep_seen;
    sym_d      = 2'h0;
    rx_ind_d   = rx_partner_lpi && link_up_q && link_eee_q; // [R09]
    case (tx_q)
      pls_pkg::PLS_ACTIVE: begin
        rx_sleep_d = 1'b0;
        if (ib_valid && ib_lpi_tx_req && lpi_ok) begin // [R01] [R23]
          tx_d  = pls_pkg::PLS_SLEEP;
          cnt_d = '0;
        end
      end
      pls_pkg::PLS_SLEEP: begin
        sym_d = 2'h1; // [R02]
        if (cnt_q < pls_pkg::CNT_W'(pls_pkg::SLEEP_CYC - 1)) cnt_d = cnt_q + 1'b1; // [R10]
        else if (!req_q) begin
          tx_d  = pls_pkg::PLS_WAKE;
          cnt_d = '0;
        end else if (link_spd_q == pls_pkg::SPD_100 || rx_sleep_d) begin // [R03] [R04]
          tx_d  = pls_pkg::PLS_QUIET;
          cnt_d = '0;
        end
      end
      pls_pkg::PLS_QUIET: begin
        if (!req_q) begin
          tx_d  = pls_pkg::PLS_WAKE; // [R06]
          cnt_d = '0;
        end else if (cnt_q >= pls_pkg::CNT_W'(pls_pkg::QUIET_CYC - 1)) begin // [R10]
          tx_d  = pls_pkg::PLS_REFRESH; // [R05]
          cnt_d = '0;
        end else cnt_d = cnt_q + 1'b1;
      end
      pls_pkg::PLS_REFRESH: begin
        sym_d = 2'h2; // [R05]
        if (cnt_q >= pls_pkg::CNT_W'(pls_pkg::REFRESH_CYC - 1)) begin // [R10]
          tx_d  = req_q ? pls_pkg::PLS_QUIET : pls_pkg::PLS_WAKE;
          cnt_d = '0;
        end else cnt_d = cnt_q + 1'b1;
      end
      pls_pkg::PLS_WAKE: begin
        sym_d = 2'h3; // [R07]
        // wake runs to its end unless the link drops; a request sent during wake is dropped, only one seen in active starts lpi
        if (cnt_q >= pls_pkg::CNT_W'(pls_pkg::WAKE_CYC - 1)) begin // [R11]
          tx_d  = pls_pkg::PLS_ACTIVE;
          cnt_d = '0;
        end else cnt_d = cnt_q + 1'b1;
      end
      default: tx_d = pls_pkg::PLS_ACTIVE;
    endcase
    // link loss aborts lpi straight to active
    if (!link_up_q) begin
      tx_d  = pls_pkg::PLS_ACTIVE;
      sym_d = 2'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_q          <= pls_pkg::PLS_ACTIVE;
      cnt_q         <= '0;
      req_q         <= 1'b0;
      rx_sleep_q    <= 1'b0;
      tx_sym        <= 2'h0;
      ib_rx_lpi_ind <= 1'b0;
    end else if (clk_en) begin
      tx_q          <= tx_d;
      cnt_q         <= cnt_d;
      req_q         <= req_d;
      rx_sleep_q    <= rx_sleep_d;
      tx_sym        <= sym_d;
      ib_rx_lpi_ind <= rx_ind_d;
    end
  end

endmodule

// ---- rtl/pls_pkg.sv ----
package pls_pkg;
  // clock period in ps
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // lpi interval times in ns
  localparam int unsigned SLEEP_NS   = 200;
  localparam int unsigned QUIET_NS   = 20000;
  localparam int unsigned REFRESH_NS = 200;
  localparam int unsigned WAKE_NS    = 16500;
  localparam int unsigned SLEEP_CYC   = (SLEEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned QUIET_CYC   = (QUIET_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned REFRESH_CYC = (REFRESH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_CYC    = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W       = 16;
  // battery-saver clock gating duty in cycles
  localparam int unsigned XTAL_OFF_CYC = 64;
  localparam int unsigned XTAL_ON_CYC  = 16;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] ADV_OFS    = 8'h08;
  localparam logic [7:0] NVM17_OFS  = 8'h0c;
  // ctrl fields
  localparam int unsigned CTRL_EEE_EN   = 0;
  localparam int unsigned CTRL_LOW_POWER_LINK_UP     = 1;
  localparam int unsigned CTRL_AN_RST   = 2;
  localparam int unsigned CTRL_FORCED   = 3;
  localparam int unsigned CTRL_PROXY    = 4;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
  localparam int unsigned NVM_LOW_POWER_LINK_UP_BIT  = 10;
  localparam logic [31:0] NVM17_RST     = 32'h0000_0000;
  localparam logic [31:0] ADV_RST       = 32'h0000_0006;

  // speeds
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  typedef enum logic [4:0] {
    PLS_ACTIVE  = 5'h01,
    PLS_SLEEP   = 5'h02,
    PLS_QUIET   = 5'h04,
    PLS_REFRESH = 5'h08,
    PLS_WAKE    = 5'h10
  } pls_tx_t;

  typedef enum logic [3:0] {
    PLS_AN_IDLE = 4'h1,
    PLS_AN_RUN  = 4'h2,
    PLS_AN_LINK = 4'h4,
    PLS_AN_SAVE = 4'h8
  } pls_an_t;
endpackage

// ---- verif/pls_power_saver_properties.sv ----
`timescale 1ns/1ps
module pls_power_saver_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       ib_valid,
  input wire logic       ib_lpi_tx_req,
  input wire logic       rx_partner_lpi,
  input wire logic       energy_detect,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [1:0] tx_sym,
  input wire logic       ib_rx_lpi_ind,
  input wire logic       an_start,
  input wire logic       xtal_drv_en,
  input wire logic       cable_disconnect_battery_saver
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  // run_q holds the length so far of the current symbol stretch, minus one
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic [1:0]  sym_q;
  always_comb begin
    run_d = (tx_sym == sym_q) ? run_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 16'h0;
      sym_q <= 2'h0;
    end else begin
      run_q <= run_d;
      sym_q <= tx_sym;
    end
  end
  ////////////////////////////////////////////////////////////
  sleep_entry_a: assert property (
    sym_q != 2'h1 && tx_sym == 2'h1 |-> $past(ib_valid && ib_lpi_tx_req, 2))
    else $error("sleep symbols without a request");
  sleep_len_a: assert property (
    sym_q == 2'h1 && tx_sym != 2'h1 |-> run_q >= pls_pkg::SLEEP_CYC - 1)
    else $error("sleep stretch too short");
  refresh_len_a: assert property (
    sym_q == 2'h2 && tx_sym != 2'h2 |-> run_q == pls_pkg::REFRESH_CYC - 1)
    else $error("refresh stretch wrong length");
  wake_len_a: assert property (
    sym_q == 2'h3 && tx_sym != 2'h3 |-> run_q == pls_pkg::WAKE_CYC - 1)
    else $error("wake stretch wrong length");
  rx_lpi_ind_a: assert property (ib_rx_lpi_ind |-> $past(rx_partner_lpi))
    else $error("partner lpi reported without cause");
  saver_entry_a: assert property (
    $rose(cable_disconnect_battery_saver) |-> !$past(energy_detect))
    else $error("saver entered with energy present");
  xtal_gate_a: assert property (
    !cable_disconnect_battery_saver && !$past(cable_disconnect_battery_saver) |-> xtal_drv_en)
    else $error("crystal drivers off outside saver");
  reconnect_an_a: assert property (
    $fell(cable_disconnect_battery_saver) |-> ##[0:16] an_start)
    else $error("no negotiation after reconnect");
  an_pulse_a: assert property (an_start |=> !an_start)
    else $error("negotiation start not a pulse");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  cover property (sym_q == 2'h1 && tx_sym == 2'h0);
  cover property (sym_q == 2'h3 && tx_sym == 2'h0);
  cover property ($rose(cable_disconnect_battery_saver));
endmodule
bind pls_power_saver pls_power_saver_chk pls_power_saver_chk_inst (
  .hclk(hclk), .hresetn(hresetn), .ib_valid(ib_valid), .ib_lpi_tx_req(ib_lpi_tx_req),
  .rx_partner_lpi(rx_partner_lpi), .energy_detect(energy_detect), .hreadyout(hreadyout),
  .hresp(hresp), .tx_sym(tx_sym), .ib_rx_lpi_ind(ib_rx_lpi_ind), .an_start(an_start),
  .xtal_drv_en(xtal_drv_en),
  .cable_disconnect_battery_saver(cable_disconnect_battery_saver));

// ---- verif/pls_lan_ctrl_model.sv ----
`timescale 1ns/1ps
module pls_lan_ctrl_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic send,
  input  wire logic lpi_bit,
  output logic      ib_valid,
  output logic      ib_lpi_tx_req
);
  logic valid_q, valid_d, req_q, req_d;
  // between messages the bit toggles so a stale value is never trusted
  always_comb begin
    valid_d = send;
    req_d   = send ? lpi_bit : ~req_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_q <= 1'b0;
      req_q   <= 1'b0;
    end else begin
      valid_q <= valid_d;
      req_q   <= req_d;
    end
  end
  assign ib_valid      = valid_q;
  assign ib_lpi_tx_req = req_q;
endmodule

// ---- verif/test_pls_power_saver.sv ----
`timescale 1ns/1ps
module test_pls_power_saver;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        send = 1'b0, lpi_bit = 1'b0, rx_sleep_seen = 1'b0, rx_partner_lpi = 1'b0;
  logic        energy_detect = 1'b1, phy_error = 1'b0, an_ok = 1'b0, an_done = 1'b0;
  logic        full_duplex = 1'b1, hreadyout, hresp, ib_valid, ib_lpi_tx_req;
  logic        full_act = 1'b1, partner_eee = 1'b1;
  logic        ib_rx_lpi_ind, an_start, an_next_page_eee, xtal_drv_en, saver;
  logic [1:0]  htrans = 2'h0, tx_sym, an_try_speed;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata;
  int          fails = 0, compares = 0, k;
  pls_power_saver pls_power_saver_inst (
    .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ib_valid(ib_valid),
    .ib_lpi_tx_req(ib_lpi_tx_req), .ib_rx_lpi_ind(ib_rx_lpi_ind),
    .rx_sleep_seen(rx_sleep_seen), .rx_partner_lpi(rx_partner_lpi),
    .energy_detect(energy_detect), .phy_error(phy_error), .partner_eee(partner_eee),
    .partner_speeds(3'h7), .an_attempt_ok(an_ok), .an_attempt_done(an_done),
    .full_duplex(full_duplex), .fully_active_device_state(full_act), .tx_sym(tx_sym),
    .an_start(an_start), .an_try_speed(an_try_speed), .an_next_page_eee(an_next_page_eee),
    .xtal_drv_en(xtal_drv_en), .cable_disconnect_battery_saver(saver));
  pls_lan_ctrl_model pls_lan_ctrl_model_inst (
    .hclk(hclk), .hresetn(hresetn), .send(send), .lpi_bit(lpi_bit),
    .ib_valid(ib_valid), .ib_lpi_tx_req(ib_lpi_tx_req));
  initial forever #2.5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
      fails++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [1:0] probe(input int s);
    case (s)
      0: return tx_sym;
      1: return {1'b0, an_start};
      2: return {1'b0, saver};
      3: return {1'b0, xtal_drv_en};
      default: return {1'b0, hreadyout};
    endcase
  endfunction
  // samples at the rising edge, so outputs are seen as they stood in the last cycle
  task automatic wt(input int s, input logic [1:0] v, input int lim);
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (probe(s) !== v && k < lim);
    compares++;
    if (probe(s) !== v) begin
      fails++;
      $display("Error wait%0d exp %h got %h", s, v, probe(s));
      final_report();
    end
  endtask
  task automatic hold(input string nm, input int s, input logic [1:0] v, input int c);
    logic [1:0] g;
    g = v;
    repeat (c) begin
      @(posedge hclk);
      if (probe(s) !== v) g = probe(s);
    end
    chk(nm, 32'(v), 32'(g));
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wt(4, 2'h1, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(4, 2'h1, 20);
    r = hrdata;
  endtask
  task automatic msg(input logic b);
    send <= 1'b1;
    lpi_bit <= b;
    @(posedge hclk);
    send <= 1'b0;
  endtask
  task automatic kick;
    phy_error <= 1'b1;
    @(posedge hclk);
    phy_error <= 1'b0;
  endtask
  task automatic att(input logic [1:0] sp, input logic ok);
    wt(1, 2'h1, 300);
    chk("an_try_speed", 32'(sp), 32'(an_try_speed));
    an_ok <= ok;
    an_done <= 1'b1;
    @(posedge hclk);
    an_done <= 1'b0;
  endtask
  task automatic exit_lpi;
    msg(1'b0);
    wt(0, 2'h3, 20);
    wt(0, 2'h0, pls_pkg::WAKE_CYC + 20);
    chk("wake_cycles", pls_pkg::WAKE_CYC, k);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r;
    bus(1'b0, 8'h00, 32'h0, r);
    chk("ctrl", pls_pkg::CTRL_RST, r);
    bus(1'b0, 8'h08, 32'h0, r);
    chk("adv", pls_pkg::ADV_RST, r);
    bus(1'b0, 8'h0c, 32'h0, r);
    chk("nvm17", pls_pkg::NVM17_RST, r);
    bus(1'b1, 8'h10, 32'hffff_ffff, r);
    bus(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    chk("next_page_eee", 32'h1, 32'(an_next_page_eee));
  endtask
  task automatic t_lpi_gig;
    msg(1'b1);
    wt(0, 2'h1, 20);
    hold("sleep_wait", 0, 2'h1, 60);
    rx_sleep_seen <= 1'b1;
    rx_partner_lpi <= 1'b1;
    @(posedge hclk);
    rx_sleep_seen <= 1'b0;
    wt(0, 2'h0, 20);
    wt(0, 2'h2, pls_pkg::QUIET_CYC + 20);
    chk("rx_lpi_ind", 32'h1, 32'(ib_rx_lpi_ind));
    rx_partner_lpi <= 1'b0;
    wt(0, 2'h0, 60);
    exit_lpi();
  endtask
  task automatic t_low_power_link_up;
    logic [31:0] r;
    bus(1'b1, 8'h00, 32'h3, r);
    hold("low_power_link_up_no_an", 1, 2'h0, 30);
    kick();
    att(2'h0, 1'b0);
    full_duplex <= 1'b0;
    att(2'h1, 1'b1);
  endtask
  task automatic t_half;
    logic [31:0] r;
    msg(1'b1);
    hold("half_dup_sym", 0, 2'h0, 60);
    full_duplex <= 1'b1;
    partner_eee <= 1'b0;
    kick();
    att(2'h0, 1'b0);
    att(2'h1, 1'b1);
    msg(1'b1);
    hold("no_eee_sym", 0, 2'h0, 60);
    partner_eee <= 1'b1;
    kick();
    att(2'h0, 1'b0);
    att(2'h1, 1'b1);
    bus(1'b1, 8'h00, 32'h13, r);
    msg(1'b1);
    hold("proxy_sym", 0, 2'h0, 60);
    bus(1'b1, 8'h00, 32'h3, r);
    msg(1'b1);
    wt(0, 2'h1, 20);
    wt(0, 2'h0, pls_pkg::SLEEP_CYC + 20);
    exit_lpi();
  endtask
  task automatic t_saver;
    logic [31:0] r;
    bus(1'b1, 8'h00, 32'h1, r);
    energy_detect <= 1'b0;
    wt(2, 2'h1, 1000);
    wt(3, 2'h0, 200);
    wt(3, 2'h1, 200);
    energy_detect <= 1'b1;
    att(2'h2, 1'b0);
    att(2'h1, 1'b0);
    att(2'h0, 1'b1);
  endtask
  task automatic t_forced;
    logic [31:0] r;
    bus(1'b1, 8'h00, 32'h9, r);
    energy_detect <= 1'b0;
    hold("forced_saver", 2, 2'h0, 1200);
    energy_detect <= 1'b1;
  endtask
  task automatic t_nvm;
    logic [31:0] r;
    bus(1'b1, 8'h0c, 32'h1 << pls_pkg::NVM_LOW_POWER_LINK_UP_BIT, r);
    bus(1'b0, 8'h0c, 32'h0, r);
    chk("nvm17_low_power_link_up", 32'h1 << pls_pkg::NVM_LOW_POWER_LINK_UP_BIT, r);
    full_act <= 1'b0;
    kick();
    att(2'h0, 1'b1);
    full_act <= 1'b1;
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    att(2'h2, 1'b1);
    t_regs();
    t_lpi_gig();
    t_low_power_link_up();
    t_half();
    t_saver();
    t_forced();
    t_nvm();
    final_report();
  end
endmodule
